// [src/tsp_defines.svh]
// constants for the temperature sensor selector and register map
`ifndef TSP_DEFINES_SVH
`define TSP_DEFINES_SVH

// fixed upper part of the device address byte
`define TSP_ADDR_PREFIX 4'h9
// general call address and its reset command byte
`define TSP_GCALL_ADDR 8'h00
`define TSP_GCALL_RESET 8'h06

// selector codes of the seven data registers
`define TSP_SEL_TEMP 8'h00
`define TSP_SEL_CFG 8'h01
`define TSP_SEL_LOW 8'h02
`define TSP_SEL_HIGH 8'h03
`define TSP_SEL_NV_CFG 8'h11
`define TSP_SEL_NV_LOW 8'h12
`define TSP_SEL_NV_HIGH 8'h13
// selector bit that picks the stored bank
`define TSP_SEL_BANK_BIT 4

// reset values
`define TSP_SEL_RESET 8'h00
`define TSP_TEMP_RESET 16'h0000
`define TSP_FACT_CFG 16'h0000
`define TSP_FACT_LOW 16'h4b00
`define TSP_FACT_HIGH 16'h5000

// bit counter positions within a byte frame
`define TSP_LAST_BIT 4'h7
`define TSP_ACK_SLOT 4'h8

`endif

// [src/tsp_link_if.sv]
// byte level link between the serial engine and the register map
`timescale 1ns/1ps
`default_nettype none

interface tsp_link_if;
   logic start; // start or repeated start seen, pulse
   logic stop; // stop seen, pulse
   logic rx_valid; // eighth bit of a byte sampled, pulse
   logic [7:0] rx_byte; // byte just shifted in
   logic ack_valid; // master answer bit sampled, pulse
   logic master_ack; // master pulled data low in its answer slot
   logic ack_drive; // pull data low in the next answer slot
   logic tx_mode; // device sends data bits
   logic [7:0] tx_byte; // byte to send, msb first

   modport engine (output start, output stop, output rx_valid,
      output rx_byte, output ack_valid, output master_ack,
      input ack_drive, input tx_mode, input tx_byte);
   modport ctrl (input start, input stop, input rx_valid,
      input rx_byte, input ack_valid, input master_ack,
      output ack_drive, output tx_mode, output tx_byte);
endinterface : tsp_link_if

`default_nettype wire

// [src/tsp_pkg.sv]
// types shared by the temperature sensor register map
package tsp_pkg;

   // transfer states of the register map controller
   typedef enum logic [2:0] {
      TSP_IDLE = 3'b000,
      TSP_ADDR = 3'b001,
      TSP_SEL = 3'b010,
      TSP_WHI = 3'b011,
      TSP_WLO = 3'b100,
      TSP_RDATA = 3'b101,
      TSP_GCALL = 3'b110,
      TSP_IGNORE = 3'b111
   } tsp_state_type;

endpackage : tsp_pkg

// [src/tsp_regmap.sv]
// selector based register map of the two-wire temperature sensor
`timescale 1ns/1ps
`default_nettype none

`include "tsp_defines.svh"

module tsp_regmap (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // two-wire serial pins, data is open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // strapped device address
   input wire logic [2:0] strap_address_pins,
   // register protection levels
   input wire logic regs_locked,
   input wire logic regs_locked_down,
   // copy request from the command decoder, one-cycle pulse
   input wire logic copy_stored_req,
   // measurement side
   input wire logic [15:0] temp_sample,
   input wire logic temp_sample_valid,
   output logic measure_start,
   // active settings seen by the sensing logic
   output logic [15:0] active_configuration,
   output logic [15:0] active_low_limit,
   output logic [15:0] active_high_limit
);

   ////////////////////////////////////////////////////////////////////
   // declarations

   tsp_link_if lk (); // byte link to the serial engine

   tsp_pkg::tsp_state_type state_r; // transfer state
   tsp_pkg::tsp_state_type state_nxt;
   logic [7:0] register_selector_r; // write-only selector
   logic [7:0] sel_nxt;
   logic ack_r; // pull data low in next answer slot
   logic ack_nxt;
   logic tx_mode_r; // device is sending
   logic tx_mode_nxt;
   logic send_hi_r; // next byte sent is the upper one
   logic send_hi_nxt;
   logic [7:0] tx_byte_r; // byte offered to the engine
   logic wr_hi; // write upper byte of selected register
   logic wr_lo; // write lower byte of selected register
   logic gcall_fire; // general call reset accepted
   logic copy_pend_r; // copy stored set into active set
   logic copy_now;
   logic writable; // selected register accepts data
   logic [15:0] temperature_result_r; // latest measurement
   logic [15:0] active_r [1:3]; // active set, index 1 cfg, 2 low, 3 high
   logic [15:0] stored_r [1:3]; // stored set, same index
   logic [15:0] read_word; // word the selector points at
   logic [1:0] entry; // index within a bank
   logic bank_stored; // selector points at the stored bank

   ////////////////////////////////////////////////////////////////////
   // serial engine

   tsp_serial_engine u_engine (
      .clk(clk),
      .nrst(nrst),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe(sda_oe),
      .lk(lk)
   );

   assign lk.ack_drive = ack_r;
   assign lk.tx_mode = tx_mode_r;
   assign lk.tx_byte = tx_byte_r;

   ////////////////////////////////////////////////////////////////////
   // selector decode

   // only the seven listed codes select; upper bits set never do
   function automatic logic sel_valid(input logic [7:0] code);
      sel_valid = (code == `TSP_SEL_TEMP) || (code == `TSP_SEL_CFG) ||
         (code == `TSP_SEL_LOW) || (code == `TSP_SEL_HIGH) ||
         (code == `TSP_SEL_NV_CFG) || (code == `TSP_SEL_NV_LOW) ||
         (code == `TSP_SEL_NV_HIGH);
   endfunction : sel_valid

   // addressing uses the lower five bits only
   assign entry = register_selector_r[1:0];
   assign bank_stored = register_selector_r[`TSP_SEL_BANK_BIT];

   // temperature result is read-only; locks block writes to both sets
   assign writable = (entry != 2'b00) && !regs_locked &&
      !regs_locked_down;

   // word for reads; selector itself is never returned
   always_comb begin
      if (entry == 2'b00) begin
         read_word = temperature_result_r;
      end else if (bank_stored) begin
         read_word = stored_r[entry];
      end else begin
         read_word = active_r[entry];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // transfer decision, one step per byte event
   always_comb begin
      state_nxt = state_r;
      sel_nxt = register_selector_r;
      ack_nxt = ack_r;
      tx_mode_nxt = tx_mode_r;
      send_hi_nxt = send_hi_r;
      wr_hi = 1'b0;
      wr_lo = 1'b0;
      gcall_fire = 1'b0;
      if (lk.start) begin
         // every frame begins with an address byte
         state_nxt = tsp_pkg::TSP_ADDR;
         ack_nxt = 1'b0;
         tx_mode_nxt = 1'b0;
      end else if (lk.stop) begin
         state_nxt = tsp_pkg::TSP_IDLE;
         ack_nxt = 1'b0;
         tx_mode_nxt = 1'b0;
      end else if (lk.rx_valid) begin
         unique case (state_r)
            tsp_pkg::TSP_ADDR: begin
               if (lk.rx_byte[7:1] ==
                  {`TSP_ADDR_PREFIX, strap_address_pins}) begin
                  ack_nxt = 1'b1;
                  if (lk.rx_byte[0]) begin
                     // read keeps whatever was selected last
                     state_nxt = tsp_pkg::TSP_RDATA;
                     tx_mode_nxt = 1'b1;
                     send_hi_nxt = 1'b1;
                  end else begin
                     // a write reloads the selector first, unless the code is refused
                     state_nxt = tsp_pkg::TSP_SEL;
                  end
               end else if (lk.rx_byte == `TSP_GCALL_ADDR) begin
                  ack_nxt = 1'b1;
                  state_nxt = tsp_pkg::TSP_GCALL;
               end else begin
                  // another device is addressed, stay silent
                  ack_nxt = 1'b0;
                  state_nxt = tsp_pkg::TSP_IGNORE;
               end
            end
            tsp_pkg::TSP_SEL: begin
               if (sel_valid(lk.rx_byte)) begin
                  sel_nxt = lk.rx_byte;
                  ack_nxt = 1'b1;
                  state_nxt = tsp_pkg::TSP_WHI;
               end else begin
                  // selector untouched, byte refused
                  ack_nxt = 1'b0;
                  state_nxt = tsp_pkg::TSP_IGNORE;
               end
            end
            tsp_pkg::TSP_WHI: begin
               // upper byte lands at once, so a one-byte write of
               // the configuration is complete on its own
               ack_nxt = writable;
               wr_hi = writable;
               state_nxt = writable ? tsp_pkg::TSP_WLO :
                  tsp_pkg::TSP_IGNORE;
            end
            tsp_pkg::TSP_WLO: begin
               ack_nxt = writable;
               wr_lo = writable;
               // bytes beyond the word are refused
               state_nxt = tsp_pkg::TSP_IGNORE;
            end
            tsp_pkg::TSP_RDATA: begin
               // let the master answer in the slot
               ack_nxt = 1'b0;
            end
            tsp_pkg::TSP_GCALL: begin
               ack_nxt = (lk.rx_byte == `TSP_GCALL_RESET);
               gcall_fire = (lk.rx_byte == `TSP_GCALL_RESET);
               if (lk.rx_byte == `TSP_GCALL_RESET) begin
                  sel_nxt = `TSP_SEL_RESET;
               end
               state_nxt = tsp_pkg::TSP_IGNORE;
            end
            tsp_pkg::TSP_IDLE,
            tsp_pkg::TSP_IGNORE: begin
               ack_nxt = 1'b0;
            end
         endcase
      end else if (lk.ack_valid && state_r == tsp_pkg::TSP_RDATA &&
         !ack_r) begin
         // ack_r high marks the slot that held our own address answer,
         // which must not advance the byte order
         if (lk.master_ack) begin
            // after the lower byte the word repeats, fresh
            send_hi_nxt = ~send_hi_r;
         end else begin
            // nack ends sending; wait for stop or start
            tx_mode_nxt = 1'b0;
            state_nxt = tsp_pkg::TSP_IGNORE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // transfer control registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= tsp_pkg::TSP_IDLE;
         ack_r <= 1'b0;
         tx_mode_r <= 1'b0;
         send_hi_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         ack_r <= ack_nxt;
         tx_mode_r <= tx_mode_nxt;
         send_hi_r <= send_hi_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // selector register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         register_selector_r <= `TSP_SEL_RESET;
      end else begin
         register_selector_r <= sel_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // byte offered for sending, refreshed every cycle
   // the engine reads it only on a falling clock, well after the
   // answer slot, so two cycles of latency are harmless
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_byte_r <= 8'h00;
      end else if (send_hi_r) begin
         tx_byte_r <= read_word[15:8];
      end else begin
         tx_byte_r <= read_word[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // copy scheduling and the measurement after reset
   // async reset cannot load a register from another, so the copy
   // is held pending and done on the first clocked cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         copy_pend_r <= 1'b1;
         measure_start <= 1'b0;
      end else begin
         copy_pend_r <= gcall_fire;
         // one conversion even if the stored setting says shutdown
         measure_start <= copy_pend_r;
      end
   end

   assign copy_now = copy_pend_r | copy_stored_req;

   ////////////////////////////////////////////////////////////////////
   // temperature result
   // a new sample is dropped while a read is under way, so the two
   // bytes of one word always belong together
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         temperature_result_r <= `TSP_TEMP_RESET;
      end else if (gcall_fire) begin
         temperature_result_r <= `TSP_TEMP_RESET;
      end else if (temp_sample_valid && state_r != tsp_pkg::TSP_RDATA) begin
         temperature_result_r <= temp_sample;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // active and stored sets, one generate entry per register pair
   for (genvar i = 1; i <= 3; i++) begin : g_pair
      localparam logic [15:0] FACT = (i == 1) ? `TSP_FACT_CFG :
         (i == 2) ? `TSP_FACT_LOW : `TSP_FACT_HIGH;
      localparam logic [1:0] IDX = 2'(i);

      // active copy: loaded from the stored copy or written directly
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            active_r[i] <= FACT;
         end else if (copy_now) begin
            active_r[i] <= stored_r[i];
         end else if (!bank_stored && entry == IDX) begin
            if (wr_hi) begin
               active_r[i][15:8] <= lk.rx_byte;
            end
            if (wr_lo) begin
               active_r[i][7:0] <= lk.rx_byte;
            end
         end
      end

      // stored copy: keeps its contents over a general call reset
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            stored_r[i] <= FACT;
         end else if (bank_stored && entry == IDX) begin
            if (wr_hi) begin
               stored_r[i][15:8] <= lk.rx_byte;
            end
            if (wr_lo) begin
               stored_r[i][7:0] <= lk.rx_byte;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // settings for the sensing logic come from the active set only
   // stored values matter only after a copy
   assign active_configuration = active_r[1];
   assign active_low_limit = active_r[2];
   assign active_high_limit = active_r[3];

endmodule : tsp_regmap

`default_nettype wire

// [src/tsp_serial_engine.sv]
// two-wire bit and byte engine of the temperature sensor
`timescale 1ns/1ps
`default_nettype none

`include "tsp_defines.svh"

module tsp_serial_engine (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // serial pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // byte side
   tsp_link_if.engine lk
);

   logic scl_q; // clock level one cycle ago
   logic sda_q; // data level one cycle ago
   logic active_r; // inside a frame
   logic [3:0] bit_r; // bit position, 8 is the answer slot
   logic [6:0] shift_r; // bits shifted in so far
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;

   assign scl_rise = scl_i & ~scl_q;
   assign scl_fall = ~scl_i & scl_q;
   // data moving while clock stays high marks frame bounds
   assign start_c = scl_i & scl_q & sda_q & ~sda_i;
   assign stop_c = scl_i & scl_q & ~sda_q & sda_i;

   ////////////////////////////////////////////////////////////////////
   // pin history, pins are already synchronous to clk
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // frame tracking, bit counting and byte events
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         active_r <= 1'b0;
         bit_r <= 4'h0;
         shift_r <= 7'h00;
         lk.start <= 1'b0;
         lk.stop <= 1'b0;
         lk.rx_valid <= 1'b0;
         lk.rx_byte <= 8'h00;
         lk.ack_valid <= 1'b0;
         lk.master_ack <= 1'b0;
      end else begin
         lk.start <= start_c;
         lk.stop <= stop_c;
         lk.rx_valid <= 1'b0;
         lk.ack_valid <= 1'b0;
         if (start_c) begin
            active_r <= 1'b1;
            bit_r <= 4'h0;
         end else if (stop_c) begin
            active_r <= 1'b0;
         end else if (active_r && scl_rise) begin
            if (bit_r == `TSP_ACK_SLOT) begin
               // answer slot: low means the master wants more
               lk.ack_valid <= 1'b1;
               lk.master_ack <= ~sda_i;
               bit_r <= 4'h0;
            end else begin
               shift_r <= {shift_r[5:0], sda_i};
               bit_r <= bit_r + 4'h1;
               if (bit_r == `TSP_LAST_BIT) begin
                  lk.rx_valid <= 1'b1;
                  lk.rx_byte <= {shift_r, sda_i};
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // data drive, changed only while the clock is low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sda_oe <= 1'b0;
         sda_o <= 1'b0;
      end else if (start_c || stop_c || !active_r) begin
         sda_oe <= 1'b0;
      end else if (scl_fall) begin
         if (bit_r == `TSP_ACK_SLOT) begin
            sda_oe <= lk.ack_drive;
         end else if (lk.tx_mode) begin
            // open drain: a one is sent by letting go
            sda_oe <= ~lk.tx_byte[3'(`TSP_LAST_BIT - bit_r)];
         end else begin
            sda_oe <= 1'b0;
         end
      end
   end

endmodule : tsp_serial_engine

`default_nettype wire

// [tb/tsp_bus_master.sv]
// behavioural two-wire bus master facing the register map
`timescale 1ns/1ps
`default_nettype none

module tsp_bus_master (
   // clock
   input wire logic clk,
   // wired data line level
   input wire logic sda_in,
   // master outputs, data pulled low only
   output logic scl,
   output logic sda_low
);
   // lines released, clock stands still between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // one bit slot: 5 cycles low, 5 high, line read mid high phase
   task automatic bit_io(input logic b, output logic r);
      @(negedge clk);
      sda_low = !b;
      repeat (4) @(negedge clk);
      scl = 1'b1;
      repeat (3) @(negedge clk);
      r = sda_in;
      repeat (2) @(negedge clk);
      scl = 1'b0;
   endtask : bit_io

   // start or repeated start before any address byte
   task automatic bus_start;
      if (!scl) begin
         @(negedge clk);
         sda_low = 1'b0;
         repeat (4) @(negedge clk);
         scl = 1'b1;
         repeat (5) @(negedge clk);
      end
      sda_low = 1'b1;
      repeat (5) @(negedge clk);
      scl = 1'b0;
   endtask : bus_start

   // stop: data rises while clock high, then bus idle
   task automatic bus_stop;
      @(negedge clk);
      sda_low = 1'b1;
      repeat (4) @(negedge clk);
      scl = 1'b1;
      repeat (5) @(negedge clk);
      sda_low = 1'b0;
      repeat (5) @(negedge clk);
   endtask : bus_stop

   // send a byte msb first, return the device answer
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask : put_byte

   // take a byte msb first, then answer ack or nack
   task automatic get_byte(input logic give_ack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(!give_ack, r);
   endtask : get_byte
endmodule : tsp_bus_master

`default_nettype wire

// [tb/tsp_regmap_chk.sv]
// port checker of the selector register map
`timescale 1ns/1ps
`default_nettype none

module tsp_regmap_chk (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // serial pins
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   // controls
   input wire logic regs_locked,
   input wire logic regs_locked_down,
   input wire logic copy_stored_req,
   // measurement and active set
   input wire logic measure_start,
   input wire logic [15:0] active_configuration,
   input wire logic [15:0] active_low_limit,
   input wire logic [15:0] active_high_limit
);
   logic [1:0] since_rst_r; // edges since reset release, saturating
   logic [47:0] act_set; // the three active words side by side
   logic lock_any; // either protection line
   assign act_set = {active_configuration, active_low_limit,
      active_high_limit};
   assign lock_any = regs_locked || regs_locked_down;

   default clocking dc @(posedge clk); endclocking
   default disable iff (!nrst);

   // count edges after release, the measurement pulse is seen at the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         since_rst_r <= 2'h0;
      end else if (since_rst_r != 2'h3) begin
         since_rst_r <= since_rst_r + 2'h1;
      end
   end

   meas_after_reset_a: assert property (since_rst_r == 2'h1 |-> measure_start)
      else $error("no measurement after reset");
   meas_pulse_a: assert property (measure_start |=> !measure_start)
      else $error("measure start longer than one cycle");
   ack_rise_low_a: assert property ($rose(sda_oe) |-> !scl_i)
      else $error("data pulled while clock high");
   oe_still_high_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
      else $error("data changed during clock high");
   ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*4])
      else $error("answer slot too short");
   open_drain_a: assert property (!sda_o)
      else $error("data output driven high");
   active_cause_a: assert property ($changed(act_set) |-> scl_i ||
      $past(copy_stored_req) || $past(copy_stored_req, 2))
      else $error("active set changed without cause");
   lock_freeze_a: assert property (lock_any && $past(lock_any) &&
      !$past(copy_stored_req) |-> $stable(act_set))
      else $error("active set written while locked");
endmodule : tsp_regmap_chk

bind tsp_regmap tsp_regmap_chk u_tsp_regmap_chk (.clk, .nrst, .scl_i,
   .sda_o, .sda_oe, .regs_locked, .regs_locked_down, .copy_stored_req,
   .measure_start, .active_configuration, .active_low_limit,
   .active_high_limit);

`default_nettype wire

// [tb/tsp_regmap_test.sv]
// self-checking bench of the selector register map
`timescale 1ns/1ps
`default_nettype none

`include "tsp_defines.svh"

module tsp_regmap_test;
   localparam logic [2:0] STRAP = 3'h5; // strapped device address
   localparam int LIMIT = 60000; // cycle ceiling, tests need far less
   logic clk, nrst, scl, m_low, sda_o, sda_oe, lck, lckd, cpy, tvld, meas;
   logic sda; // wired data line with pull-up
   logic [15:0] tsmp, a_cfg, a_low, a_high, w;
   logic [3:0] acks; // address, selector, upper, lower answers
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   assign sda = !(sda_oe || m_low);

   tsp_regmap u_tsp_regmap (.clk(clk), .nrst(nrst), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .strap_address_pins(STRAP), .regs_locked(lck),
      .regs_locked_down(lckd), .copy_stored_req(cpy), .temp_sample(tsmp),
      .temp_sample_valid(tvld), .measure_start(meas),
      .active_configuration(a_cfg), .active_low_limit(a_low),
      .active_high_limit(a_high));
   tsp_bus_master u_tsp_bus_master (.clk(clk), .sda_in(sda), .scl(scl),
      .sda_low(m_low));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // hang guard: a run past the ceiling counts as a mismatch
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         tally_and_finish();
      end
   end

   task tally_and_finish;
      if (failures == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task do_reset;
      nrst = 1'b0;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
   endtask : do_reset

   // write frame always carries a fresh selector
   task write_reg(input logic [7:0] sel, input logic [15:0] v, input int nb);
      acks = 4'h0;
      u_tsp_bus_master.bus_start();
      u_tsp_bus_master.put_byte({`TSP_ADDR_PREFIX, STRAP, 1'b0}, acks[3]);
      u_tsp_bus_master.put_byte(sel, acks[2]);
      for (int i = 0; i < nb; i++) begin
         u_tsp_bus_master.put_byte(v[15 - 8 * i -: 8], acks[1 - i]);
      end
      u_tsp_bus_master.bus_stop();
   endtask : write_reg

   // read frame: word, then master ack must repeat the upper byte
   task read_reg;
      logic a;
      logic [7:0] again;
      u_tsp_bus_master.bus_start();
      u_tsp_bus_master.put_byte({`TSP_ADDR_PREFIX, STRAP, 1'b1}, a);
      u_tsp_bus_master.get_byte(1'b1, w[15:8]);
      u_tsp_bus_master.get_byte(1'b1, w[7:0]);
      u_tsp_bus_master.get_byte(1'b0, again);
      u_tsp_bus_master.bus_stop();
      chk({15'h0, a}, 16'h1);
      chk({8'h0, again}, {8'h0, w[15:8]});
   endtask : read_reg

   task t_reset_state;
      read_reg();
      chk(w, `TSP_TEMP_RESET);
      chk(a_cfg, `TSP_FACT_CFG);
      chk(a_low, `TSP_FACT_LOW);
      chk(a_high, `TSP_FACT_HIGH);
   endtask : t_reset_state

   // one sample, read twice with no selector reload
   task t_temp_persist;
      tsmp = 16'h1940;
      tvld = 1'b1;
      @(negedge clk);
      tvld = 1'b0;
      read_reg();
      chk(w, 16'h1940);
      read_reg();
      chk(w, 16'h1940);
   endtask : t_temp_persist

   // every writable selector, then the stored set copied across
   task t_write_all;
      logic [7:0] sels [6] = '{8'h01, 8'h02, 8'h03, 8'h11, 8'h12, 8'h13};
      for (int i = 0; i < 6; i++) begin
         write_reg(sels[i], {sels[i], 8'h5a}, 2);
         chk({12'h0, acks}, 16'hf);
         read_reg();
         chk(w, {sels[i], 8'h5a});
      end
      chk(a_cfg, 16'h015a);
      chk(a_high, 16'h035a);
      cpy = 1'b1;
      @(negedge clk);
      cpy = 1'b0;
      repeat (2) @(negedge clk);
      chk(a_cfg, 16'h115a);
      chk(a_low, 16'h125a);
      chk(a_high, 16'h135a);
   endtask : t_write_all

   // refused selectors keep the last good selection
   task t_bad_sel;
      logic [7:0] bad [4] = '{8'h21, 8'h04, 8'h10, 8'he0};
      for (int i = 0; i < 4; i++) begin
         write_reg(bad[i], 16'hffff, 2);
         chk({12'h0, acks}, 16'h8);
         read_reg();
         chk(w, 16'h135a);
      end
   endtask : t_bad_sel

   task t_temp_write;
      write_reg(8'h00, 16'h7777, 2);
      chk({12'h0, acks}, 16'hc);
      read_reg();
      chk(w, 16'h1940);
   endtask : t_temp_write

   // each protection line alone blocks the write
   task t_lock;
      for (int i = 0; i < 2; i++) begin
         {lckd, lck} = 2'h1 << i;
         write_reg(8'h01, 16'h0f0f, 2);
         {lckd, lck} = 2'h0;
         chk({12'h0, acks}, 16'hc);
         chk(a_cfg, 16'h115a);
      end
   endtask : t_lock

   task t_upper_only;
      write_reg(8'h01, 16'h8800, 1);
      chk({12'h0, acks}, 16'he);
      chk(a_cfg, 16'h885a);
   endtask : t_upper_only

   // another strap value must not be answered
   task t_bad_addr;
      logic a;
      u_tsp_bus_master.bus_start();
      u_tsp_bus_master.put_byte({`TSP_ADDR_PREFIX, STRAP ^ 3'h1, 1'b0}, a);
      u_tsp_bus_master.bus_stop();
      chk({15'h0, a}, 16'h0);
   endtask : t_bad_addr

   // general call reset: selector, result and active set reload
   task t_gcall;
      logic a, b;
      u_tsp_bus_master.bus_start();
      u_tsp_bus_master.put_byte(`TSP_GCALL_ADDR, a);
      u_tsp_bus_master.put_byte(`TSP_GCALL_RESET, b);
      u_tsp_bus_master.bus_stop();
      chk({14'h0, a, b}, 16'h3);
      read_reg();
      chk(w, `TSP_TEMP_RESET);
      chk(a_cfg, 16'h115a);
   endtask : t_gcall

   initial begin
      {lck, lckd, cpy, tvld} = 4'h0;
      tsmp = 16'h0000;
      do_reset();
      t_reset_state();
      t_temp_persist();
      t_write_all();
      t_bad_sel();
      t_temp_write();
      t_lock();
      t_upper_only();
      t_bad_addr();
      t_gcall();
      do_reset();
      t_reset_state();
      tally_and_finish();
   end
endmodule : tsp_regmap_test

`default_nettype wire
